// ===== design/sub_exec.sv
// Contract
// - literal subtract computes literal minus accumulator, result to accumulator.
// - register subtract computes addressed register minus accumulator, two's complement.
// - destination bit clear writes accumulator, set writes register back.
// - bank bit clear selects access bank, set selects bank pointer bank.
// - both update negative, wrap, carry, half-borrow, zero; carry means no borrow.
// - register subtract is one word, four phases decode read compute write.
// - literal subtract is one word, four phases decode read compute write.
`timescale 1ns/1ps
`default_nettype none
module sub_exec
    import subop_pkg::*;
(
    // clock and reset
    input wire logic CLK_SYS_I,
    input wire logic SYS_RST_I,
    // instruction presented at decode, held for the cycle
    input wire logic INSTR_VALID_I,
    input wire logic [subop_pkg::OPC_W-1:0] INSTR_I,
    // bank pointer and register read data
    input wire logic [3:0] BANK_PTR_I,
    input wire logic [subop_pkg::DATA_W-1:0] FILE_RDATA_I,
    // register access
    output logic [11:0] FILE_ADDR_O,
    output logic FILE_RD_O,
    output logic FILE_WR_O,
    output logic [subop_pkg::DATA_W-1:0] FILE_WDATA_O,
    // accumulator and flags
    output logic [subop_pkg::DATA_W-1:0] ACC_O,
    output logic [subop_pkg::FLG_W-1:0] FLAGS_O,
    // phase indicator and completion pulse
    output logic [3:0] PHASE_O,
    output logic DONE_O
);
    import subop_pkg::*;

    phase_t phase_r, phase_nxt;
    logic [OPC_W-1:0] instr_r;
    logic busy_r;
    logic [DATA_W-1:0] opa_r, acc_r, res_r, wdata_r;
    logic [FLG_W-1:0] flags_r, flg_res_r;
    logic [11:0] addr_r;
    logic is_lit, is_file, hold_lit, hold_file;
    logic [DATA_W-1:0] diff;
    logic carry, half, wrap;

    assign is_lit = INSTR_I[15:8] == LIT_OPC;
    assign is_file = INSTR_I[15:10] == FILE_OPC;
    assign hold_lit = instr_r[15:8] == LIT_OPC;
    assign hold_file = instr_r[15:10] == FILE_OPC;

    // phase sequencer: one instruction cycle of four phases
    // four phase cycle
    always_comb begin
        phase_nxt = phase_r;
        case (phase_r)
            PH_DECODE: if (INSTR_VALID_I && (is_lit || is_file)) phase_nxt = PH_READ;
            PH_READ: phase_nxt = PH_PROCESS;
            PH_PROCESS: phase_nxt = PH_WRITE;
            PH_WRITE: phase_nxt = PH_DECODE;
            default: phase_nxt = PH_DECODE;
        endcase
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (SYS_RST_I) begin
            phase_r <= PH_DECODE;
        end else begin
            phase_r <= phase_nxt;
        end
    end

    // instruction latch at decode
    always_ff @(posedge CLK_SYS_I) begin
        if (SYS_RST_I) begin
            instr_r <= '0;
            busy_r <= 1'b0;
        end else if (phase_r == PH_DECODE) begin
            busy_r <= INSTR_VALID_I && (is_lit || is_file);
            if (INSTR_VALID_I) instr_r <= INSTR_I;
        end else if (phase_r == PH_WRITE) begin
            busy_r <= 1'b0;
        end
    end

    // address formation from bank bit
    // bank select
    always_ff @(posedge CLK_SYS_I) begin
        if (SYS_RST_I) begin
            addr_r <= '0;
        end else if (phase_r == PH_DECODE && INSTR_VALID_I) begin
            addr_r <= {(INSTR_I[BANK_BIT] ? BANK_PTR_I : ACCESS_BANK), INSTR_I[7:0]};
        end
    end

    // operand read: literal or register data
    // literal operand
    always_ff @(posedge CLK_SYS_I) begin
        if (SYS_RST_I) begin
            opa_r <= '0;
        end else if (phase_r == PH_READ) begin
            opa_r <= hold_lit ? instr_r[7:0] : FILE_RDATA_I;
        end
    end

    sub_unit #(
        .W(DATA_W)
    ) u_sub (
        .min_i(opa_r),
        .sub_i(acc_r),
        .diff_o(diff),
        .carry_o(carry),
        .half_o(half),
        .wrap_o(wrap)
    );

    // compute phase: capture difference and flags
    // flag update
    always_ff @(posedge CLK_SYS_I) begin
        if (SYS_RST_I) begin
            res_r <= '0;
            flg_res_r <= '0;
        end else if (phase_r == PH_PROCESS) begin
            res_r <= diff;
            flg_res_r <= {diff[DATA_W-1], wrap, (diff == '0), half, carry};
        end
    end

    // write phase: accumulator and flags
    // destination select
    always_ff @(posedge CLK_SYS_I) begin
        if (SYS_RST_I) begin
            acc_r <= ACC_RST;
            flags_r <= '0;
        end else if (phase_r == PH_WRITE && busy_r) begin
            flags_r <= flg_res_r;
            if (hold_lit || !instr_r[DEST_BIT]) acc_r <= res_r;
        end
    end

    // register write data
    always_ff @(posedge CLK_SYS_I) begin
        if (SYS_RST_I) begin
            wdata_r <= '0;
        end else if (phase_r == PH_PROCESS) begin
            wdata_r <= diff;
        end
    end

    assign FILE_ADDR_O = addr_r;
    assign FILE_RD_O = (phase_r == PH_READ) && hold_file;
    assign FILE_WR_O = (phase_r == PH_WRITE) && busy_r && hold_file && instr_r[DEST_BIT];
    assign FILE_WDATA_O = wdata_r;
    assign ACC_O = acc_r;
    assign FLAGS_O = flags_r;
    assign PHASE_O = phase_r;
    assign DONE_O = (phase_r == PH_WRITE) && busy_r;

    // literal result lands in accumulator after write phase
    // literal result
    lit_acc_a: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I)
        (phase_r == PH_WRITE && busy_r && hold_lit) |=> acc_r == $past(res_r))
        else $error("literal result not in accumulator");

    // register result equals register minus accumulator
    // register difference
    file_diff_a: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I)
        (phase_r == PH_PROCESS && busy_r) |=> res_r == 8'($past(opa_r) - $past(acc_r)))
        else $error("difference wrong");

    // destination set keeps accumulator and writes register
    // destination check
    dest_file_a: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I)
        (phase_r == PH_WRITE && busy_r && hold_file && instr_r[DEST_BIT]) |-> FILE_WR_O ##1 $stable(acc_r))
        else $error("destination handling wrong");

    // bank bit clear forces access bank
    // access bank
    bank_sel_a: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I)
        (phase_r == PH_DECODE && INSTR_VALID_I && !INSTR_I[BANK_BIT]) |=> addr_r[11:8] == ACCESS_BANK)
        else $error("bank select wrong");

    // zero and negative follow result
    // zero negative
    zero_neg_a: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I)
        (phase_r == PH_WRITE && busy_r) |=> (flags_r[FLG_Z] == ($past(res_r) == '0))
            && (flags_r[FLG_N] == $past(res_r[DATA_W-1])))
        else $error("zero or negative flag wrong");

    // destination clear puts the difference in the accumulator, no register write
    // accumulator destination
    dest_acc_a: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I)
        (phase_r == PH_WRITE && busy_r && hold_file && !instr_r[DEST_BIT]) |-> !FILE_WR_O
            ##1 acc_r == $past(res_r))
        else $error("accumulator destination wrong");

    // signed wrap when operand signs differ and the result sign leaves the minuend's
    // wrap flag
    wrap_flag_a: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I)
        (phase_r == PH_PROCESS && busy_r) |=> flg_res_r[FLG_OV] == (($past(opa_r[DATA_W-1])
            != $past(acc_r[DATA_W-1])) && (res_r[DATA_W-1] != $past(opa_r[DATA_W-1]))))
        else $error("signed wrap flag wrong");

    // carry means no borrow
    // carry sense
    carry_sense_a: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I)
        (phase_r == PH_PROCESS && busy_r) |=> flg_res_r[FLG_C] == ($past(opa_r) >= $past(acc_r)))
        else $error("carry sense wrong");

    // half borrow from low nibble
    // half borrow
    half_flag_a: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I)
        (phase_r == PH_PROCESS && busy_r) |=> flg_res_r[FLG_DC] == ($past(opa_r[3:0]) >= $past(acc_r[3:0])))
        else $error("half borrow wrong");

    // accepted instruction completes exactly three cycles later
    // cycle length
    four_phase_a: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I)
        (phase_r == PH_DECODE && INSTR_VALID_I && (is_lit || is_file)) |-> ##3 DONE_O ##1 phase_r == PH_DECODE)
        else $error("instruction cycle length wrong");
endmodule // sub_exec
`default_nettype wire

// ===== design/subop_pkg.sv
package subop_pkg;
    // opcode fields
    localparam int OPC_W = 16;
    localparam int DATA_W = 8;
    localparam logic [7:0] LIT_OPC = 8'h08;        // upper byte of literal subtract
    localparam logic [5:0] FILE_OPC = 6'h17;       // upper six bits of register subtract
    localparam int DEST_BIT = 9;
    localparam int BANK_BIT = 8;
    // reset values
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [3:0] BANK_PTR_RST = 4'h0;
    localparam logic [3:0] ACCESS_BANK = 4'h0;     // bank used when bank bit is clear
    // phases per instruction cycle
    localparam int PHASES = 4;
    // flag bit positions in the flag output
    localparam int FLG_C = 0;
    localparam int FLG_DC = 1;
    localparam int FLG_Z = 2;
    localparam int FLG_OV = 3;
    localparam int FLG_N = 4;
    localparam int FLG_W = 5;
    typedef enum logic [3:0] {
        PH_DECODE = 4'h1,
        PH_READ = 4'h2,
        PH_PROCESS = 4'h4,
        PH_WRITE = 4'h8
    } phase_t;
endpackage

// ===== design/sub_unit.sv
`timescale 1ns/1ps
`default_nettype none
// subtractor: minuend minus subtrahend with processor-style flags
module sub_unit #(
    parameter int W = 8
) (
    // operands
    input wire logic [W-1:0] min_i,
    input wire logic [W-1:0] sub_i,
    // results
    output logic [W-1:0] diff_o,
    output logic carry_o,
    output logic half_o,
    output logic wrap_o
);
    logic [W:0] full;
    logic [4:0] low;
    // refuse widths too narrow to hold a full nibble plus a sign bit
    if (W < 5) begin : g_width_check
        $error("sub_unit width too small");
    end
    // carry set when no borrow, i.e. min plus inverted sub plus one
    assign full = {1'b0, min_i} + {1'b0, ~sub_i} + {{W{1'b0}}, 1'b1};
    assign low = {1'b0, min_i[3:0]} + {1'b0, ~sub_i[3:0]} + 5'h01;
    assign diff_o = full[W-1:0];
    assign carry_o = full[W];
    assign half_o = low[4];
    assign wrap_o = (min_i[W-1] != sub_i[W-1]) && (full[W-1] != min_i[W-1]);
endmodule // sub_unit
`default_nettype wire

// ===== test/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import subop_pkg::*;
    logic clk, rst, vld, rd, wr, done;
    logic [15:0] instr;
    logic [3:0] bank, phase;
    logic [7:0] rdata, acc_exp, wdata, acc;
    logic [11:0] addr;
    logic [4:0] flags;
    logic [7:0] lits [7] = '{8'h05, 8'h07, 8'h02, 8'h03, 8'h02, 8'h7f, 8'h10};
    int fails = 0;
    int checks_done = 0;

    sub_exec i_dut (.CLK_SYS_I(clk), .SYS_RST_I(rst), .INSTR_VALID_I(vld), .INSTR_I(instr),
        .BANK_PTR_I(bank), .FILE_RDATA_I(rdata), .FILE_ADDR_O(addr), .FILE_RD_O(rd),
        .FILE_WR_O(wr), .FILE_WDATA_O(wdata), .ACC_O(acc), .FLAGS_O(flags),
        .PHASE_O(phase), .DONE_O(done));

    // 50 mhz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // compare and count
    task automatic check(input logic [23:0] got, input logic [23:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // verdict and end of run
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // one instruction through decode, read, compute and write
    task automatic run_op(input logic [15:0] op, input logic [3:0] bp, input logic [7:0] rv);
        logic is_file, d;
        logic [7:0] m, diff;
        logic [4:0] f_exp;
        is_file = (op[15:10] == FILE_OPC);
        d = is_file && op[DEST_BIT];
        m = is_file ? rv : op[7:0];
        diff = m - acc_exp;
        f_exp = {diff[7], (m[7] != acc_exp[7]) && (diff[7] != m[7]), diff == 8'h00,
                 m[3:0] >= acc_exp[3:0], m >= acc_exp};
        @(posedge clk);
        vld <= 1'b1;
        instr <= op;
        bank <= bp;
        rdata <= rv;
        @(posedge clk);
        vld <= 1'b0;
        bank <= ~bp; // pointer only counts at decode
        #1;
        check(phase, 4'h2, "read phase");
        check(rd, is_file, "read strobe");
        if (is_file) check(addr, {(op[BANK_BIT] ? bp : ACCESS_BANK), op[7:0]}, "address");
        @(posedge clk);
        #1;
        check(phase, 4'h4, "compute phase");
        @(posedge clk);
        #1;
        check({phase, done, wr}, {4'h8, 1'b1, d}, "write phase");
        if (d) check(wdata, diff, "write data");
        @(posedge clk);
        #1;
        if (!d) acc_exp = diff;
        check({done, wr}, 2'h0, "strobes end");
        check(acc, acc_exp, "accumulator");
        check(flags, f_exp, "flags");
    endtask

    // a neighbouring opcode held at decode must be ignored
    task automatic run_refused(input logic [15:0] op);
        @(posedge clk);
        vld <= 1'b1;
        instr <= op;
        repeat (4) begin
            @(posedge clk);
            #1;
            check({done, wr, rd}, 3'h0, "ignored opcode");
        end
        @(posedge clk);
        vld <= 1'b0;
        #1;
        check(acc, acc_exp, "accumulator kept");
    endtask

    // main sequence
    initial begin
        rst = 1'b1;
        vld = 1'b0;
        instr = 16'h0000;
        bank = 4'h0;
        rdata = 8'h00;
        acc_exp = ACC_RST;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        #1;
        check({acc, flags, phase}, {ACC_RST, 5'h00, 4'h1}, "reset state");
        // literal cases: positive, zero, negative, signed wrap
        foreach (lits[i]) run_op({LIT_OPC, lits[i]}, 4'h3, 8'h5a);
        // register cases over every destination and bank choice
        for (int i = 0; i < 4; i++) begin
            run_op({FILE_OPC, i[1:0], 8'h34 + 8'(i)}, 4'ha, 8'h91 - 8'(i * 16));
        end
        run_op({FILE_OPC, 2'b11, 8'hff}, 4'hf, 8'h00);
        run_op({FILE_OPC, 2'b00, 8'h00}, 4'h5, 8'h80);
        run_refused(16'h5b12);
        run_refused(16'h0912);
        run_op({LIT_OPC, 8'h80}, 4'h0, 8'h00);
        tally_and_finish();
    end

    // watchdog against a hang
    initial begin
        #20000;
        fails++;
        tally_and_finish();
    end
endmodule // tb
`default_nettype wire
